// [rtl/risc_core_sequencer.sv]
// Fetch/execute sequencer of the 8-bit core: phases, counter, stack, decode, writeback
`timescale 1ns/1ps
`include "seq_params.svh"
module risc_core_sequencer #(
    parameter int PC_W = `PC_WIDTH
) (
    input  wire logic                          mclk,
    input  wire logic                          resetn,
    input  wire logic [`INSTR_WIDTH-1:0]       prog_data,
    output logic      [PC_W-1:0]               prog_addr,
    input  wire logic [`DATA_WIDTH-1:0]        file_rdata,
    output logic      [`FILE_ADDR_WIDTH-1:0]   file_addr,
    output logic      [`DATA_WIDTH-1:0]        file_wdata,
    output logic                               file_we,
    output logic                               phase_one,
    output logic                               phase_two,
    output logic                               phase_three,
    output logic                               phase_four,
    output logic      [`DATA_WIDTH-1:0]        w_out,
    output logic      [`DATA_WIDTH-1:0]        status_out
);
    import seq_pkg::*;

    // Bank mapping: upper half of the 32-byte window is banked by pointer bits 6:5
    function automatic logic [6:0] bank_map(input logic [4:0] low5, input logic [7:0] ptr);
        bank_map = low5[4] ? {ptr[6:5], low5} : {2'b00, low5};
    endfunction

    // Byte-group opcode to arithmetic operation
    function automatic alu_op_t byte_op(input logic [3:0] op4);
        unique case (op4)
            4'h0: byte_op = ALU_PASS_W;
            4'h1: byte_op = ALU_ZERO;
            4'h2: byte_op = ALU_SUB;
            4'h3: byte_op = ALU_DEC;
            4'h4: byte_op = ALU_IOR;
            4'h5: byte_op = ALU_AND;
            4'h6: byte_op = ALU_XOR;
            4'h7: byte_op = ALU_ADD;
            4'h8: byte_op = ALU_PASS_A;
            4'h9: byte_op = ALU_COM;
            4'hA: byte_op = ALU_INC;
            4'hB: byte_op = ALU_DEC;
            4'hC: byte_op = ALU_RRF;
            4'hD: byte_op = ALU_RLF;
            4'hE: byte_op = ALU_SWAP;
            4'hF: byte_op = ALU_INC;
        endcase
    endfunction

    logic                        rst_meta_ff;
    logic                        rst_sync_ff;
    phase_t                      phase_ff;
    logic [PC_W-1:0]             pc_ff;
    logic [PC_W-1:0]             prog_addr_ff;
    logic [PC_W-1:0]             stack_top_ff;
    logic [PC_W-1:0]             stack_low_ff;
    logic [`INSTR_WIDTH-1:0]     ir_ff;
    logic [7:0]                  w_ff;
    logic [7:0]                  status_ff;
    logic [7:0]                  pointer_ff;
    logic [7:0]                  operand_ff;
    logic [6:0]                  file_addr_ff;
    logic [7:0]                  file_wdata_ff;
    logic                        file_we_ff;

    logic [4:0]                  fsel;
    logic [6:0]                  nxt_file_addr;
    logic                        self_indirect;
    logic [7:0]                  nxt_operand;
    alu_op_t                     alu_op;
    logic [7:0]                  alu_a;
    logic [7:0]                  alu_result;
    logic                        alu_carry;
    logic                        alu_digit;
    logic                        w_wr;
    logic                        f_wr;
    logic                        upd_z;
    logic                        upd_c;
    logic                        upd_dc;
    logic                        skip;
    logic                        do_goto;
    logic                        do_call;
    logic                        do_ret;
    logic                        pc_wr;
    logic                        flow_change;
    logic [10:0]                 page_base;
    logic [7:0]                  nxt_status;

    // Reset release through two stages; asynchronous assert only
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // Four-phase ring; each phase lasts one input clock
    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            phase_ff <= PH_ONE;
        end else begin
            unique case (phase_ff)
                PH_ONE:   phase_ff <= PH_TWO;
                PH_TWO:   phase_ff <= PH_THREE;
                PH_THREE: phase_ff <= PH_FOUR;
                PH_FOUR:  phase_ff <= PH_ONE;
            endcase
        end
    end

    assign phase_one   = (phase_ff == PH_ONE);
    assign phase_two   = (phase_ff == PH_TWO);
    assign phase_three = (phase_ff == PH_THREE);
    assign phase_four  = (phase_ff == PH_FOUR);

    // Operand addressing: file 0 means use the pointer register
    always_comb begin
        fsel          = (ir_ff[4:0] == 5'h00) ? pointer_ff[4:0] : ir_ff[4:0];
        nxt_file_addr = bank_map(fsel, pointer_ff);
        self_indirect = (nxt_file_addr == `ADDR_INDIRECT);
    end

    // Core-held locations are answered locally, the rest by the file
    always_comb begin
        unique case (file_addr_ff)
            `ADDR_INDIRECT: nxt_operand = 8'h00;
            `ADDR_PC_LOW:   nxt_operand = pc_ff[7:0];
            `ADDR_STATUS:   nxt_operand = status_ff;
            `ADDR_POINTER:  nxt_operand = pointer_ff;
            default:        nxt_operand = file_rdata;
        endcase
    end

    // Decode of the 33-word set; every word is one program location
    always_comb begin
        alu_op  = ALU_PASS_A;
        alu_a   = operand_ff;
        w_wr    = 1'b0;
        f_wr    = 1'b0;
        upd_z   = 1'b0;
        upd_c   = 1'b0;
        upd_dc  = 1'b0;
        skip    = 1'b0;
        do_goto = 1'b0;
        do_call = 1'b0;
        do_ret  = 1'b0;
        unique case (ir_ff[11:10])
            2'b00: begin
                alu_op = byte_op(ir_ff[9:6]);
                // Misc word with d clear: no-op and unmodelled control words
                if (ir_ff[9:6] != 4'h0 || ir_ff[5]) begin
                    w_wr = ~ir_ff[5] & (ir_ff[9:6] != 4'h0);
                    f_wr = ir_ff[5];
                end
                upd_z  = !(ir_ff[9:6] inside {4'h0, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF});
                upd_c  = ir_ff[9:6] inside {4'h2, 4'h7, 4'hC, 4'hD};
                upd_dc = ir_ff[9:6] inside {4'h2, 4'h7};
                skip   = (ir_ff[9:6] inside {4'hB, 4'hF}) && (alu_result == 8'h00);
            end
            2'b01: begin
                alu_op = ir_ff[8] ? ALU_BSET : ALU_BCLR;
                f_wr   = ~ir_ff[9];
                skip   = ir_ff[9] && (operand_ff[ir_ff[7:5]] == ir_ff[8]);
            end
            2'b10: begin
                alu_a   = ir_ff[7:0];
                w_wr    = (ir_ff[9:8] == 2'b00);
                do_ret  = (ir_ff[9:8] == 2'b00);
                do_call = (ir_ff[9:8] == 2'b01);
                do_goto = ir_ff[9];
            end
            2'b11: begin
                alu_a  = ir_ff[7:0];
                w_wr   = 1'b1;
                upd_z  = (ir_ff[9:8] != 2'b00);
                unique case (ir_ff[9:8])
                    2'b00: alu_op = ALU_PASS_A;
                    2'b01: alu_op = ALU_IOR;
                    2'b10: alu_op = ALU_AND;
                    2'b11: alu_op = ALU_XOR;
                endcase
            end
        endcase
    end

    accumulator_alu u_alu (
        .op        (alu_op),
        .a         (alu_a),
        .w         (w_ff),
        .bit_sel   (ir_ff[7:5]),
        .carry_in  (status_ff[`ST_CARRY]),
        .result    (alu_result),
        .carry_out (alu_carry),
        .digit_out (alu_digit)
    );

    // Flow control: page bits select among four 512-word pages
    always_comb begin
        page_base   = {status_ff[`ST_PAGE_HI:`ST_PAGE_LO], 9'h000};
        pc_wr       = f_wr && (file_addr_ff == `ADDR_PC_LOW);
        flow_change = skip | do_goto | do_call | do_ret | pc_wr;
    end

    // Counter: step in phase one, redirect at end of execute
    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            pc_ff        <= PC_W'(`PC_RESET);
            prog_addr_ff <= PC_W'(`PC_RESET);
        end else if (phase_one) begin
            prog_addr_ff <= pc_ff;
            pc_ff        <= pc_ff + PC_W'(1);
        end else if (phase_four) begin
            if (do_goto)
                pc_ff <= PC_W'(page_base | {2'b00, ir_ff[8:0]});
            else if (do_call || pc_wr)
                pc_ff <= PC_W'(page_base | {3'b000, (do_call ? ir_ff[7:0] : alu_result)});
            else if (do_ret)
                pc_ff <= stack_top_ff;
        end
    end

    // Two-entry stack; a third call silently drops the oldest
    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            stack_top_ff <= '0;
            stack_low_ff <= '0;
        end else if (phase_four && do_call) begin
            stack_low_ff <= stack_top_ff;
            // Counter is already two ahead; the discarded prefetch is the return point
            stack_top_ff <= prog_addr_ff;
        end else if (phase_four && do_ret) begin
            stack_top_ff <= stack_low_ff;
        end
    end

    // Capture next word in phase four while current finishes
    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff)
            ir_ff <= `NOP_WORD;
        else if (phase_four)
            ir_ff <= flow_change ? `NOP_WORD : prog_data;
    end

    // Operand address in phase one, operand sampled in phase two
    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            file_addr_ff <= '0;
            operand_ff   <= 8'h00;
        end else if (phase_one) begin
            file_addr_ff <= nxt_file_addr;
        end else if (phase_two) begin
            operand_ff   <= nxt_operand;
        end
    end

    // External write strobe held through phase four only
    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            file_we_ff    <= 1'b0;
            file_wdata_ff <= 8'h00;
        end else if (phase_three) begin
            file_wdata_ff <= alu_result;
            // Indirect self-access and core-held locations never reach the file
            file_we_ff    <= f_wr && !self_indirect && file_addr_ff > `ADDR_POINTER;
        end else begin
            file_we_ff    <= 1'b0;
        end
    end

    // Accumulator writeback
    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff)
            w_ff <= `W_RESET;
        else if (phase_four && w_wr)
            w_ff <= alu_result;
    end

    // Pointer register writeback
    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff)
            pointer_ff <= `POINTER_RESET;
        else if (phase_four && f_wr && file_addr_ff == `ADDR_POINTER)
            pointer_ff <= alu_result;
    end

    // Status: direct write first, flag updates from the same operation win
    always_comb begin
        nxt_status = (f_wr && file_addr_ff == `ADDR_STATUS) ? alu_result : status_ff;
        if (upd_z)
            nxt_status[`ST_ZERO] = (alu_result == 8'h00);
        if (upd_c)
            nxt_status[`ST_CARRY] = alu_carry;
        if (upd_dc)
            nxt_status[`ST_DIGIT] = alu_digit;
    end

    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff)
            status_ff <= `STATUS_RESET;
        else if (phase_four)
            status_ff <= nxt_status;
    end

    assign prog_addr  = prog_addr_ff;
    assign file_addr  = file_addr_ff;
    assign file_wdata = file_wdata_ff;
    assign file_we    = file_we_ff;
    assign w_out      = w_ff;
    assign status_out = status_ff;

endmodule // risc_core_sequencer

// [rtl/seq_params.svh]
// Constants for the fetch/execute sequencer: addresses, fields, resets, counts
`ifndef SEQ_PARAMS_SVH
`define SEQ_PARAMS_SVH

// Phase count per instruction cycle
`define PHASES_PER_CYCLE 4
// Widths
`define PC_WIDTH         11
`define INSTR_WIDTH      12
`define DATA_WIDTH       8
`define FILE_ADDR_WIDTH  7
// Memory geometry
`define PAGE_WORDS       512
`define PAGE_COUNT       4
`define FILE_REGS        80
`define DIRECT_REGS      32
`define BANK_BYTES       16
`define STACK_DEPTH      2
`define INSTR_COUNT      33
// Reset values
`define PC_RESET         11'h7FF
`define STATUS_RESET     8'h18
`define POINTER_RESET    8'h00
`define W_RESET          8'h00
`define NOP_WORD         12'h000
// File locations held inside the core
`define ADDR_INDIRECT    7'h00
`define ADDR_PC_LOW      7'h02
`define ADDR_STATUS      7'h03
`define ADDR_POINTER     7'h04
// Status field positions
`define ST_CARRY         0
`define ST_DIGIT         1
`define ST_ZERO          2
`define ST_PAGE_LO       5
`define ST_PAGE_HI       6

`endif

// [rtl/seq_pkg.sv]
// Types shared by the sequencer and its arithmetic unit
package seq_pkg;

    // One-hot phase of the instruction cycle
    typedef enum logic [3:0] {
        PH_ONE   = 4'b0001,
        PH_TWO   = 4'b0010,
        PH_THREE = 4'b0100,
        PH_FOUR  = 4'b1000
    } phase_t;

    // Arithmetic unit operations
    typedef enum logic [3:0] {
        ALU_PASS_A = 4'h0,
        ALU_PASS_W = 4'h1,
        ALU_ZERO   = 4'h2,
        ALU_ADD    = 4'h3,
        ALU_SUB    = 4'h4,
        ALU_AND    = 4'h5,
        ALU_IOR    = 4'h6,
        ALU_XOR    = 4'h7,
        ALU_COM    = 4'h8,
        ALU_INC    = 4'h9,
        ALU_DEC    = 4'hA,
        ALU_RRF    = 4'hB,
        ALU_RLF    = 4'hC,
        ALU_SWAP   = 4'hD,
        ALU_BCLR   = 4'hE,
        ALU_BSET   = 4'hF
    } alu_op_t;

endpackage

// [rtl/accumulator_alu.sv]
// Eight-bit arithmetic unit between the accumulator and a file operand
`timescale 1ns/1ps
module accumulator_alu (
    input  seq_pkg::alu_op_t op,
    input  wire logic [7:0]  a,
    input  wire logic [7:0]  w,
    input  wire logic [2:0]  bit_sel,
    input  wire logic        carry_in,
    output logic      [7:0]  result,
    output logic             carry_out,
    output logic             digit_out
);
    import seq_pkg::*;

    logic [8:0] sum9;
    logic [4:0] nib5;
    logic [7:0] mask;

    // Shared adder; subtract is a plus two's complement of w, carry = no borrow
    always_comb begin
        mask = 8'h01 << bit_sel;
        if (op == ALU_SUB) begin
            sum9 = {1'b0, a} + {1'b0, ~w} + 9'h001;
            nib5 = {1'b0, a[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
        end else begin
            sum9 = {1'b0, a} + {1'b0, w};
            nib5 = {1'b0, a[3:0]} + {1'b0, w[3:0]};
        end
    end

    // Operation select
    always_comb begin
        carry_out = carry_in;
        digit_out = nib5[4];
        unique case (op)
            ALU_PASS_A: result = a;
            ALU_PASS_W: result = w;
            ALU_ZERO:   result = 8'h00;
            ALU_ADD, ALU_SUB: begin
                result    = sum9[7:0];
                carry_out = sum9[8];
            end
            ALU_AND:    result = a & w;
            ALU_IOR:    result = a | w;
            ALU_XOR:    result = a ^ w;
            ALU_COM:    result = ~a;
            ALU_INC:    result = a + 8'h01;
            ALU_DEC:    result = a - 8'h01;
            ALU_RRF: begin
                result    = {carry_in, a[7:1]};
                carry_out = a[0];
            end
            ALU_RLF: begin
                result    = {a[6:0], carry_in};
                carry_out = a[7];
            end
            ALU_SWAP:   result = {a[3:0], a[7:4]};
            ALU_BCLR:   result = a & ~mask;
            ALU_BSET:   result = a | mask;
        endcase
    end

endmodule // accumulator_alu

// [testbench/seq_props.sv]
// Port-level timing checks for the fetch/execute sequencer
`timescale 1ns/1ps
`include "seq_params.svh"
module seq_props #(
    parameter int PC_W = `PC_WIDTH
) (
    input wire logic                        mclk,
    input wire logic                        resetn,
    input wire logic [`INSTR_WIDTH-1:0]     prog_data,
    input wire logic [PC_W-1:0]             prog_addr,
    input wire logic [`DATA_WIDTH-1:0]      file_rdata,
    input wire logic [`FILE_ADDR_WIDTH-1:0] file_addr,
    input wire logic [`DATA_WIDTH-1:0]      file_wdata,
    input wire logic                        file_we,
    input wire logic                        phase_one,
    input wire logic                        phase_two,
    input wire logic                        phase_three,
    input wire logic                        phase_four,
    input wire logic [`DATA_WIDTH-1:0]      w_out,
    input wire logic [`DATA_WIDTH-1:0]      status_out
);
    logic [1:0] sync_ff;
    logic       kill_ff;
    logic       branch_now;

    // Mirror of the core's two-flop reset release
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) sync_ff <= 2'h0;
        else sync_ff <= {sync_ff[0], 1'b1};
    end

    // Live goto, call or return being fetched; skips are invisible here
    assign branch_now = phase_four && !kill_ff && (prog_data[11:9] == 3'h5
                        || prog_data[11:8] == 4'h9 || prog_data[11:8] == 4'h8);

    // Marks the word fetched after a live branch, which never executes
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) kill_ff <= 1'b0;
        else if (phase_four) kill_ff <= branch_now;
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!sync_ff[1]);

    chk_phase_onehot: assert property ($onehot({phase_four, phase_three, phase_two, phase_one}))
        else $error("phase outputs not one-hot");
    chk_phase_rotate: assert property (phase_one |=> phase_two ##1 phase_three ##1 phase_four ##1 phase_one)
        else $error("phase order broken");
    chk_fetch_hold: assert property (!phase_one |=> $stable(prog_addr))
        else $error("fetch address moved outside phase one");
    chk_seq_step: assert property (phase_four && prog_data[11:10] == 2'h3
                                   |-> ##6 prog_addr == $past(prog_addr, 4) + 1'b1)
        else $error("counter did not step after literal op");
    chk_literal_load: assert property (phase_four && !kill_ff && prog_data[11:8] inside {4'hC, 4'h8}
                                       |-> ##5 w_out == $past(prog_data[7:0], 5))
        else $error("literal not loaded into accumulator");
    chk_goto_target: assert property (phase_four && !kill_ff && prog_data[11:9] == 3'h5
                                      |-> ##6 prog_addr[8:0] == $past(prog_data[8:0], 6))
        else $error("jump target not fetched");
    chk_call_target: assert property (phase_four && !kill_ff && prog_data[11:8] == 4'h9
                                      |-> ##6 prog_addr[8:0] == {1'b0, $past(prog_data[7:0], 6)})
        else $error("call target not fetched");
    chk_branch_void: assert property (branch_now |-> ##8 !file_we ##1 $stable(w_out))
        else $error("word after branch was executed");
    chk_we_pulse: assert property (file_we |-> phase_four ##1 !file_we)
        else $error("write strobe outside phase four");
    chk_we_core_addr: assert property (file_we |-> file_addr > 7'h04)
        else $error("external write to a core-held location");
    chk_reset_pc: assert property (disable iff (!resetn) $rose(sync_ff[1])
                                   |-> prog_addr == 11'h7FF && phase_one)
        else $error("counter not all ones at reset release");

    cover property (branch_now && prog_data[11:8] == 4'h9);
    cover property (branch_now && prog_data[11:8] == 4'h8);
    cover property (file_we && file_addr == 7'h10);
endmodule // seq_props

bind risc_core_sequencer seq_props #(.PC_W(PC_W)) u_props (.mclk(mclk), .resetn(resetn),
    .prog_data(prog_data), .prog_addr(prog_addr), .file_rdata(file_rdata),
    .file_addr(file_addr), .file_wdata(file_wdata), .file_we(file_we),
    .phase_one(phase_one), .phase_two(phase_two), .phase_three(phase_three),
    .phase_four(phase_four), .w_out(w_out), .status_out(status_out));

// [testbench/prog_file_model.sv]
// Program memory and external data file facing the sequencer
`timescale 1ns/1ps
`include "seq_params.svh"
module prog_file_model #(
    parameter int PC_W = `PC_WIDTH
) (
    input  wire logic                        mclk,
    input  wire logic [PC_W-1:0]             prog_addr,
    output logic      [`INSTR_WIDTH-1:0]     prog_data,
    input  wire logic [`FILE_ADDR_WIDTH-1:0] file_addr,
    input  wire logic [`DATA_WIDTH-1:0]      file_wdata,
    input  wire logic                        file_we,
    output logic      [`DATA_WIDTH-1:0]      file_rdata
);
    logic [`INSTR_WIDTH-1:0] rom [0:(1<<PC_W)-1];
    logic [`DATA_WIDTH-1:0]  ram [0:127];

    // Unprogrammed words are no-ops; file bytes start non-zero so a zero read means something
    initial begin
        for (int i = 0; i < (1 << PC_W); i++) rom[i] = `NOP_WORD;
        for (int i = 0; i < 128; i++) ram[i] = 8'hC3 ^ i[7:0];
    end

    assign prog_data  = rom[prog_addr];
    assign file_rdata = ram[file_addr];

    // Byte write at the strobe edge
    always @(posedge mclk) begin
        if (file_we === 1'b1) ram[file_addr] <= file_wdata;
    end
endmodule // prog_file_model

// [testbench/risc_core_fetch_execute_sequencer_test.sv]
// Self-checking bench running a short program through the sequencer
`timescale 1ns/1ps
`include "seq_params.svh"
module risc_core_fetch_execute_sequencer_test;
    typedef struct {logic [6:0] addr; logic [7:0] data; int gap;} row_t;
    typedef struct {logic [6:0] addr; logic [7:0] data; int at;} wr_t;

    logic        mclk;
    logic        resetn;
    logic [11:0] prog_data;
    logic [10:0] prog_addr;
    logic [7:0]  file_rdata;
    logic [6:0]  file_addr;
    logic [7:0]  file_wdata;
    logic        file_we;
    logic        phase_one;
    logic        phase_two;
    logic        phase_three;
    logic        phase_four;
    logic [7:0]  w_out;
    logic [7:0]  status_out;
    int          fail_count;
    int          checks_done;
    int          cyc;
    wr_t         wq[$];
    // Expected external writes; gap is clocks since the previous one
    row_t        rows[6] = '{'{7'h08, 8'h5A, 0}, '{7'h08, 8'h69, 8}, '{7'h10, 8'h33, 16},
                             '{7'h09, 8'h00, 24}, '{7'h0A, 8'h21, 36}, '{7'h09, 8'h04, 12}};
    // Main program from address 0; a taken bit-skip guards a store that must not land
    logic [11:0] prog_words[20] = '{12'hC5A, 12'h028, 12'hC0F, 12'h1E8, 12'hC10, 12'h024,
        12'hC33, 12'h020, 12'hC00, 12'h024, 12'hC77, 12'h020, 12'h200, 12'h029, 12'h940,
        12'h02A, 12'h6E8, 12'h02B, 12'h549, 12'hA13};

    risc_core_sequencer #(.PC_W(11)) uut (.mclk(mclk), .resetn(resetn),
        .prog_data(prog_data), .prog_addr(prog_addr), .file_rdata(file_rdata),
        .file_addr(file_addr), .file_wdata(file_wdata), .file_we(file_we),
        .phase_one(phase_one), .phase_two(phase_two), .phase_three(phase_three),
        .phase_four(phase_four), .w_out(w_out), .status_out(status_out));

    prog_file_model #(.PC_W(11)) u_mem (.mclk(mclk), .prog_addr(prog_addr),
        .prog_data(prog_data), .file_addr(file_addr), .file_wdata(file_wdata),
        .file_we(file_we), .file_rdata(file_rdata));

    always #2.5 mclk = ~mclk;

    // Log every external write with the clock count it landed on
    always @(posedge mclk) begin
        cyc++;
        if (file_we === 1'b1) wq.push_back('{file_addr, file_wdata, cyc});
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Release reset and compare the write log against the table
    task automatic run_program();
        int n;
        n = 0;
        wq.delete();
        resetn <= 1'b1;
        while (wq.size() < 6 && n < 400) begin
            @(posedge mclk);
            n++;
        end
        repeat (60) @(posedge mclk);
        check("write count", 32'd6, wq.size());
        for (int i = 0; i < 6 && i < wq.size(); i++) begin
            check("write addr", {25'h0, rows[i].addr}, {25'h0, wq[i].addr});
            check("write data", {24'h0, rows[i].data}, {24'h0, wq[i].data});
            if (i > 0) check("write gap", rows[i].gap, wq[i].at - wq[i-1].at);
        end
        @(negedge mclk);
        check("accumulator", 32'h21, {24'h0, w_out});
        check("status flags", 32'h1E, {24'h0, status_out});
    endtask

    // Reset state seen at the ports while reset is held
    task automatic reset_state();
        @(negedge mclk);
        check("reset fetch addr", 32'h7FF, {21'h0, prog_addr});
        check("reset write strobe", 32'h0, {31'h0, file_we});
        check("reset phase", 32'h1, {31'h0, phase_one});
        check("reset status", 32'h18, {24'h0, status_out});
    endtask

    initial begin
        mclk = 1'b0;
        resetn = 1'b0;
        fail_count = 0;
        checks_done = 0;
        cyc = 0;
        #1;
        // Literals, add, indirect store, self-read, nested calls, skip, idle loop
        for (int i = 0; i < 20; i++) u_mem.rom[i] = prog_words[i];
        u_mem.rom[11'h7FF] = 12'hA00;
        u_mem.rom[11'h040] = 12'h950;
        u_mem.rom[11'h041] = 12'h821;
        u_mem.rom[11'h050] = 12'h842;
        repeat (20) @(posedge mclk);
        reset_state();
        @(posedge mclk);
        run_program();
        // Reset while the program sits in its idle loop, then the whole run must repeat
        repeat (37) @(posedge mclk);
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_state();
        @(posedge mclk);
        run_program();
        end_of_test();
    end

    // Hang guard, well past the two program runs
    initial begin
        #25000;
        fail_count++;
        end_of_test();
    end
endmodule // risc_core_fetch_execute_sequencer_test
